// >>> design/jtdr_core.sv
// jtdr_core: bypass, boundary and identification test data registers
// assumes: scan clock and serial input come from pins; tap state and
// instruction come from the tap controller on clk
// Function
// - bypass register is one single stage
// - bypass, clamp, highz route through bypass
// - boundary register: shift chain plus parallel latch
// - identification: 32-bit shift plus latched output
// - identification selected on ident and reset
// - id holds revision, part, maker, one
// - three-bit instruction codes choose the register
// - id loads on capture rising edge
// - selected register shifts; others hold
// - highz floats every digital output
`timescale 1ns/100ps
module jtdr_core
    import jtdr_pkg::*;
#(
    parameter int               BSR_W    = 8,
    parameter logic [3:0]       ID_REV   = 4'h1,    // arbitrary value
    parameter logic [15:0]      ID_PART  = 16'h00A5, // arbitrary value
    parameter logic [10:0]      ID_MFR   = 11'h055  // arbitrary value
) (
    // clock and reset
    input  wire logic             clk,
    input  wire logic             rst,
    // scan pins
    input  wire logic             scan_clock,
    input  wire logic             scan_serial_in,
    output logic                  scan_serial_out,
    // tap controller state and instruction
    input  wire logic             tap_test_reset,
    input  wire logic             tap_capture_dr,
    input  wire logic             tap_shift_dr,
    input  wire logic             tap_update_dr,
    input  wire logic [2:0]       cur_instr,
    // digital pins of the device
    input  wire logic [BSR_W-1:0] pin_in,
    input  wire logic [BSR_W-1:0] core_out,
    input  wire logic [BSR_W-1:0] core_oe,
    output logic      [BSR_W-1:0] pin_out,
    output logic      [BSR_W-1:0] pin_oe
);

    // =====================================================================
    // pin synchronisers and edge finding
    logic [JTDR_SYNC_STAGES-1:0] clk_sync;
    logic [JTDR_SYNC_STAGES-1:0] tdi_sync;
    logic                        clk_level;
    logic                        sc_rise;
    logic                        sc_fall;
    logic                        tdi;

    // three stages; only the second and third are looked at
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            clk_sync <= '0;
            tdi_sync <= '0;
        end else begin
            clk_sync <= {clk_sync[JTDR_SYNC_STAGES-2:0], scan_clock};
            tdi_sync <= {tdi_sync[JTDR_SYNC_STAGES-2:0], scan_serial_in};
        end
    end

    // accepted scan clock level, changes when stages two and three agree
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            clk_level <= 1'b0;
        end else if (clk_sync[1] == clk_sync[2]) begin
            clk_level <= clk_sync[2];
        end
    end

    assign sc_rise = (clk_sync[1] == clk_sync[2]) && clk_sync[2] && !clk_level;
    assign sc_fall = (clk_sync[1] == clk_sync[2]) && !clk_sync[2] && clk_level;

    // accepted serial input level, same agreement rule as the clock
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            tdi <= 1'h0;
        end else if (tdi_sync[1] == tdi_sync[2]) begin
            tdi <= tdi_sync[2];
        end
    end

    // digital pin levels pass the same three stages before capture
    logic [BSR_W-1:0] pin_s1;
    logic [BSR_W-1:0] pin_s2;
    logic [BSR_W-1:0] pin_s3;
    logic [BSR_W-1:0] pin_level;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            pin_s1 <= '0;
            pin_s2 <= '0;
            pin_s3 <= '0;
        end else begin
            pin_s1 <= pin_in;
            pin_s2 <= pin_s1;
            pin_s3 <= pin_s2;
        end
    end

    // each bit takes its new level only where stages two and three agree
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            pin_level <= '0;
        end else begin
            pin_level <= (pin_s3 & ~(pin_s2 ^ pin_s3)) | (pin_level & (pin_s2 ^ pin_s3));
        end
    end

    // =====================================================================
    // register selection
    jtdr_sel_t sel;

    always_comb begin
        if (tap_test_reset) begin
            sel = JTDR_SEL_ID;
        end else begin
            case (cur_instr)
                JTDR_IR_EXTEST, JTDR_IR_SAMPLE: sel = JTDR_SEL_BSR;
                JTDR_IR_IDENT:                  sel = JTDR_SEL_ID;
                JTDR_IR_BYPASS, JTDR_IR_CLAMP, JTDR_IR_HIGHZ: sel = JTDR_SEL_BYP;
                default:                        sel = JTDR_SEL_BYP;
            endcase
        end
    end

    // step strobes for each register
    logic cap_bsr, cap_id, sh_bsr, sh_id, up_bsr, up_id;
    assign cap_bsr = sc_rise && tap_capture_dr && sel == JTDR_SEL_BSR;
    assign cap_id  = sc_rise && tap_capture_dr && sel == JTDR_SEL_ID;
    assign sh_bsr  = sc_rise && tap_shift_dr && sel == JTDR_SEL_BSR;
    assign sh_id   = sc_rise && tap_shift_dr && sel == JTDR_SEL_ID;
    assign up_bsr  = sc_fall && tap_update_dr && sel == JTDR_SEL_BSR;
    assign up_id   = sc_fall && tap_update_dr && sel == JTDR_SEL_ID;

    // =====================================================================
    // bypass stage
    logic bypass;

    // single stage, shifts only when selected
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            bypass <= JTDR_BYP_CAPTURE;
        end else if (sc_rise && sel == JTDR_SEL_BYP) begin
            if (tap_capture_dr) begin
                bypass <= JTDR_BYP_CAPTURE;
            end else if (tap_shift_dr) begin
                bypass <= tdi;
            end
        end
    end

    // =====================================================================
    // boundary and identification registers
    logic [BSR_W-1:0]     bsr_shift, bsr_par;
    logic [JTDR_ID_W-1:0] id_shift, id_par, id_value;

    assign id_value = {ID_REV, ID_PART, ID_MFR, JTDR_ID_REQ};

    // boundary chain samples the pins on capture
    jtdr_shift_latch #(.W(BSR_W)) u_bsr (
        .clk        (clk),
        .rst        (rst),
        .capture_en (cap_bsr),
        .shift_en   (sh_bsr),
        .update_en  (up_bsr),
        .cap_data   (pin_level),
        .ser_in     (tdi),
        .shift_q    (bsr_shift),
        .par_q      (bsr_par)
    );

    // identification loads its value on capture
    jtdr_shift_latch #(.W(JTDR_ID_W)) u_id (
        .clk        (clk),
        .rst        (rst),
        .capture_en (cap_id),
        .shift_en   (sh_id),
        .update_en  (up_id),
        .cap_data   (id_value),
        .ser_in     (tdi),
        .shift_q    (id_shift),
        .par_q      (id_par)
    );

    // =====================================================================
    // serial output, changes on the falling scan clock edge
    logic next_tdo;
    always_comb begin
        case (sel)
            JTDR_SEL_BSR: next_tdo = bsr_shift[0];
            JTDR_SEL_ID:  next_tdo = id_shift[0];
            default:      next_tdo = bypass;
        endcase
    end

    // output follows the selected register end stage
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            scan_serial_out <= JTDR_TDO_RESET;
        end else if (sc_fall) begin
            scan_serial_out <= next_tdo;
        end
    end

    // =====================================================================
    // digital pin drive
    // highz floats all outputs; extest and clamp drive latch
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            pin_out <= '0;
            pin_oe  <= '0;
        end else if (cur_instr == JTDR_IR_HIGHZ && !tap_test_reset) begin
            pin_out <= '0;
            pin_oe  <= '0;
        end else if ((cur_instr == JTDR_IR_EXTEST || cur_instr == JTDR_IR_CLAMP) && !tap_test_reset) begin
            pin_out <= bsr_par;
            pin_oe  <= '1;
        end else begin
            pin_out <= core_out;
            pin_oe  <= core_oe;
        end
    end

    // =====================================================================
    // assertions
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    sequence s_shift_id;
        sc_rise && tap_shift_dr && !tap_capture_dr && sel == JTDR_SEL_ID;
    endsequence
    sequence s_shift_other;
        sc_rise && tap_shift_dr && sel != JTDR_SEL_BYP;
    endsequence

    bypass_shift_a: assert property ((sc_rise && tap_shift_dr && !tap_capture_dr && sel == JTDR_SEL_BYP) |=> bypass == $past(tdi)) else $error("bypass did not take serial input");
    short_path_a: assert property ((!tap_test_reset && (cur_instr == JTDR_IR_CLAMP || cur_instr == JTDR_IR_HIGHZ || cur_instr == JTDR_IR_BYPASS)) |-> sel == JTDR_SEL_BYP) else $error("short path not selected");
    bsr_update_a: assert property (up_bsr |=> bsr_par == $past(bsr_shift)) else $error("boundary latch not updated");
    id_update_a: assert property (up_id |=> id_par == $past(id_shift)) else $error("id latch not updated");
    id_shift_a: assert property (s_shift_id |=> id_shift == {$past(tdi), $past(id_shift[JTDR_ID_W-1:1])}) else $error("id shift wrong");
    id_select_a: assert property (tap_test_reset |-> sel == JTDR_SEL_ID) else $error("id not selected in reset");
    id_reqbit_a: assert property (cap_id |=> id_shift[JTDR_ID_REQ_POS] == JTDR_ID_REQ) else $error("id required bit lost");
    sample_sel_a: assert property ((!tap_test_reset && cur_instr == JTDR_IR_SAMPLE) |-> sel == JTDR_SEL_BSR) else $error("sample code misrouted");
    id_capture_a: assert property (cap_id |=> id_shift == id_value) else $error("id not loaded on capture");
    bypass_hold_a: assert property (s_shift_other |=> $stable(bypass)) else $error("bypass moved while not selected");
    tdo_follow_a: assert property (sc_fall |=> scan_serial_out == $past(next_tdo)) else $error("serial output wrong");
    highz_float_a: assert property ((cur_instr == JTDR_IR_HIGHZ && !tap_test_reset)[*2] |-> pin_oe == '0) else $error("outputs driven under highz");

endmodule

// >>> design/jtdr_pkg.sv
// jtdr_pkg: constants shared by the scan test data register block
// assumes: a three-bit instruction from the neighbouring tap controller
package jtdr_pkg;

    // =====================================================================
    // instruction codes
    localparam int        JTDR_IR_W       = 3;
    localparam logic [2:0] JTDR_IR_EXTEST = 3'h0;
    localparam logic [2:0] JTDR_IR_IDENT  = 3'h1;
    localparam logic [2:0] JTDR_IR_SAMPLE = 3'h2;
    localparam logic [2:0] JTDR_IR_CLAMP  = 3'h3;
    localparam logic [2:0] JTDR_IR_HIGHZ  = 3'h4;
    localparam logic [2:0] JTDR_IR_BYPASS = 3'h7;

    // =====================================================================
    // identification layout
    localparam int JTDR_ID_W      = 32;
    localparam int JTDR_REV_W     = 4;
    localparam int JTDR_PART_W    = 16;
    localparam int JTDR_MFR_W     = 11;
    localparam int JTDR_ID_REQ_POS = 0;
    localparam logic JTDR_ID_REQ  = 1'b1;

    // =====================================================================
    // reset values and synchroniser depth
    localparam logic JTDR_BYP_CAPTURE = 1'b0;
    localparam logic JTDR_TDO_RESET   = 1'b0;
    localparam int   JTDR_SYNC_STAGES = 3;

    // data register selected onto the serial path
    typedef enum logic [1:0] {
        JTDR_SEL_BYP,
        JTDR_SEL_BSR,
        JTDR_SEL_ID
    } jtdr_sel_t;

endpackage

// >>> design/jtdr_shift_latch.sv
// jtdr_shift_latch: capture/shift stage with a separately latched parallel output
// assumes: one-cycle enables, shift moves toward bit 0
`timescale 1ns/100ps
module jtdr_shift_latch #(
    parameter int W = 8
) (
    // clock and reset
    input  wire logic         clk,
    input  wire logic         rst,
    // controls
    input  wire logic         capture_en,
    input  wire logic         shift_en,
    input  wire logic         update_en,
    // data
    input  wire logic [W-1:0] cap_data,
    input  wire logic         ser_in,
    output logic      [W-1:0] shift_q,
    output logic      [W-1:0] par_q
);

    // shift path: parallel load on capture, one stage per shift
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            shift_q <= '0;
        end else if (capture_en) begin
            shift_q <= cap_data;
        end else if (shift_en) begin
            shift_q <= {ser_in, shift_q[W-1:1]};
        end
    end

    // parallel latch keeps outputs steady while shifting
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            par_q <= '0;
        end else if (update_en) begin
            par_q <= shift_q;
        end
    end

endmodule

// >>> tb/jtdr_tap_model.sv
// jtdr_tap_model: stand-in for the boundary-scan controller on the far side
// assumes: bench clk at 125 MHz; one scan cycle is 8 clk (64 ns), changes at clk fall
`timescale 1ns/100ps
module jtdr_tap_model (
    // bench clock
    input  wire logic  clk,
    // scan pins and tap state toward the block
    output logic       scan_clock,
    output logic       scan_serial_in,
    output logic       tap_test_reset,
    output logic       tap_capture_dr,
    output logic       tap_shift_dr,
    output logic       tap_update_dr,
    output logic [2:0] cur_instr,
    input  wire logic  scan_serial_out,
    // sampled serial output toward the bench
    output logic       tdo_seen,
    output logic       tdo_bit
);
    // =====================================================================
    // idle levels: controller starts in test reset, scan clock stands still
    initial begin
        scan_clock = 1'b0;
        scan_serial_in = 1'b1;
        tap_test_reset = 1'b1;
        {tap_capture_dr, tap_shift_dr, tap_update_dr} = 3'h0;
        cur_instr = 3'h7;
        tdo_seen = 1'b0;
        tdo_bit = 1'b0;
    end

    task automatic set_instr(input logic [2:0] code, input logic trst);
        @(negedge clk);
        cur_instr = code;
        tap_test_reset = trst;
    endtask

    // one scan cycle: st 1 capture, 2 shift, 3 update; output looked at before the fall
    task automatic tick(input logic [1:0] st, input logic tdi, input logic look);
        @(negedge clk);
        scan_serial_in = tdi;
        @(negedge clk);
        scan_clock = 1'b1;
        tap_capture_dr = (st == 2'h1);
        tap_shift_dr = (st == 2'h2);
        tap_update_dr = (st == 2'h3);
        repeat (2) @(negedge clk);
        tdo_seen = look;
        tdo_bit = scan_serial_out;
        @(negedge clk);
        tdo_seen = 1'b0;
        @(negedge clk);
        scan_clock = 1'b0;
        scan_serial_in = ~tdi; // hold over, no stale data
        repeat (2) @(negedge clk);
    endtask
endmodule

// >>> tb/tb_top.sv
// tb_top: self-checking bench for the scan test data registers
// assumes: jtdr_tap_model drives the scan side; the bench drives the device pins
`timescale 1ns/100ps
module tb_top
    import jtdr_pkg::*;
;
    // =====================================================================
    // signals; id fields are arbitrary values
    localparam int          BSR_W = 8;
    localparam logic [31:0] T_ID  = {4'hB, 16'h3C5A, 11'h2E7, 1'b1};
    logic             clk;
    logic             rst;
    logic             scan_clock;
    logic             scan_serial_in;
    logic             scan_serial_out;
    logic             tap_test_reset;
    logic             tap_capture_dr;
    logic             tap_shift_dr;
    logic             tap_update_dr;
    logic [2:0]       cur_instr;
    logic [BSR_W-1:0] pin_in;
    logic [BSR_W-1:0] core_out;
    logic [BSR_W-1:0] core_oe;
    logic [BSR_W-1:0] pin_out;
    logic [BSR_W-1:0] pin_oe;
    logic             tdo_seen;
    logic             tdo_bit;
    logic             exp_q[$];
    logic [2:0]       byp [5] = '{JTDR_IR_BYPASS, JTDR_IR_CLAMP, JTDR_IR_HIGHZ, 3'h5, 3'h6};
    logic [31:0]      d;
    logic [31:0]      e;
    int               mismatches;
    int               checks_done;
    int               cycles;

    jtdr_tap_model tm (.clk(clk), .scan_clock(scan_clock), .scan_serial_in(scan_serial_in),
        .tap_test_reset(tap_test_reset), .tap_capture_dr(tap_capture_dr), .tap_shift_dr(tap_shift_dr),
        .tap_update_dr(tap_update_dr), .cur_instr(cur_instr), .scan_serial_out(scan_serial_out),
        .tdo_seen(tdo_seen), .tdo_bit(tdo_bit));
    jtdr_core #(.BSR_W(BSR_W), .ID_REV(T_ID[31:28]), .ID_PART(T_ID[27:12]), .ID_MFR(T_ID[11:1])) dut (
        .clk(clk), .rst(rst), .scan_clock(scan_clock), .scan_serial_in(scan_serial_in),
        .scan_serial_out(scan_serial_out), .tap_test_reset(tap_test_reset), .tap_capture_dr(tap_capture_dr),
        .tap_shift_dr(tap_shift_dr), .tap_update_dr(tap_update_dr), .cur_instr(cur_instr),
        .pin_in(pin_in), .core_out(core_out), .core_oe(core_oe), .pin_out(pin_out), .pin_oe(pin_oe));

    // =====================================================================
    // comparisons and verdict
    task automatic check_bit(input string what, input logic exp, input logic seen);
        checks_done++;
        if (seen !== exp) begin
            mismatches++;
            $display("BAD %s expected %b seen %b", what, exp, seen);
        end
    endtask
    task automatic check_pins(input string what, input logic [7:0] exp, input logic [7:0] seen);
        checks_done++;
        if (seen !== exp) begin
            mismatches++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic test_done();
        if (mismatches == 0 && checks_done > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    // one data scan: optional capture, n looked-at shifts, then update
    task automatic scan_dr(input int n, input logic cap, input logic [31:0] tdi, input logic [31:0] exp);
        // without capture an idle scan cycle lets the newly selected register reach the output
        tm.tick(cap ? 2'h1 : 2'h0, 1'b0, 1'b0);
        for (int i = 0; i < n; i++) begin
            exp_q.push_back(exp[i]);
            tm.tick(2'h2, tdi[i], 1'b1);
        end
        tm.tick(2'h3, 1'b0, 1'b0);
    endtask

    // new instruction and core values; mode 0 normal, 1 latched, 2 floating
    task automatic pins(input logic [2:0] code, input logic trst, input int mode, input logic [7:0] lat);
        tm.set_instr(code, trst);
        core_out = 8'($urandom);
        core_oe = 8'($urandom);
        pin_in = 8'($urandom);
        repeat (2) @(negedge clk);
        if (mode == 2) check_pins("pin_oe", 8'h00, pin_oe);
        else begin
            check_pins("pin_out", (mode == 1) ? lat : core_out, pin_out);
            check_pins("pin_oe", (mode == 1) ? 8'hFF : core_oe, pin_oe);
        end
    endtask

    // =====================================================================
    // clock, serial monitor and hang limit
    always #4 clk = ~clk;
    always @(posedge clk) begin
        if (tdo_seen === 1'b1) check_bit("scan_serial_out", exp_q.pop_front(), tdo_bit);
    end
    always @(posedge clk) begin
        cycles++;
        if (cycles == 6000) begin
            mismatches++;
            test_done();
        end
    end

    // main sequence
    initial begin
        void'($urandom(32'h8fb9));
        {clk, rst, pin_in, core_out, core_oe} = {2'b01, 24'h0};
        {mismatches, checks_done, cycles} = {32'd0, 32'd0, 32'd0};
        repeat (8) @(negedge clk);
        rst = 1'b0;
        repeat (4) @(negedge clk);
        pins(JTDR_IR_EXTEST, 1'b1, 0, 8'h00);
        tm.set_instr(JTDR_IR_IDENT, 1'b0);
        scan_dr(32, 1'b1, $urandom, T_ID);
        e = $urandom;
        scan_dr(32, 1'b1, e, T_ID);
        scan_dr(32, 1'b0, $urandom, e);
        foreach (byp[k]) begin
            tm.set_instr(byp[k], 1'b0);
            d = $urandom;
            scan_dr(8, 1'b1, d, {d[6:0], JTDR_BYP_CAPTURE});
        end
        tm.set_instr(JTDR_IR_SAMPLE, 1'b0);
        d = $urandom;
        scan_dr(8, 1'b1, d, {24'h0, pin_in});
        pins(JTDR_IR_SAMPLE, 1'b0, 0, 8'h00);
        pins(JTDR_IR_EXTEST, 1'b0, 1, d[7:0]);
        pins(JTDR_IR_CLAMP, 1'b0, 1, d[7:0]);
        pins(JTDR_IR_HIGHZ, 1'b0, 2, 8'h00);
        e = $urandom;
        scan_dr(8, 1'b1, e, {e[6:0], 1'b0});
        tm.set_instr(JTDR_IR_SAMPLE, 1'b0);
        scan_dr(8, 1'b0, e, d);
        pins(JTDR_IR_EXTEST, 1'b0, 1, e[7:0]);
        scan_dr(8, 1'b1, d, {24'h0, pin_in});
        repeat (4) @(negedge clk);
        test_done();
    end
endmodule
